// *** rtl/cvr_pkg.sv ***
// shared constants for the converter voltage and ramp register bank
`default_nettype none
package cvr_pkg;
	// register offsets
	localparam logic [7:0] RAMP_CTRL_ADDR  = 8'h03;
	localparam logic [7:0] STEP_DOWN_ADDR  = 8'h04;
	localparam logic [7:0] FIRST_REG_ADDR  = 8'h05;
	localparam logic [7:0] SECOND_REG_ADDR = 8'h06;
	// ramp control field positions
	localparam int SCALING_ENABLE_BIT = 4;
	localparam int SLEW_CODE_MSB      = 3;
	localparam int SLEW_CODE_LSB      = 0;
	// reset values
	localparam logic       SCALING_ENABLE_RST = 1'b0;
	localparam logic [3:0] SLEW_CODE_RST      = 4'h9;
	localparam logic [7:0] STEP_DOWN_RST      = 8'h02;
	localparam logic [7:0] SECOND_REG_RST     = 8'h0E;
	localparam logic [7:0] READ_UNMAPPED      = 8'h00;
	// code ranges and voltage scale of the step-down converter
	localparam logic [3:0]  SLEW_CODE_MAX  = 4'hB;
	localparam logic [7:0]  STEP_DOWN_MAX  = 8'h10;
	localparam logic [11:0] STEP_DOWN_BASE_MV = 12'h320; // 800 mV
	localparam logic [11:0] CODE_STEP_MV      = 12'h064; // 100 mV
	localparam logic [11:0] STEP_DOWN_RST_MV  =
		12'(STEP_DOWN_BASE_MV + 12'(STEP_DOWN_RST) * CODE_STEP_MV);
	// slew rates are given per microsecond
	localparam int CLK_PERIOD_NS = 10;
	localparam int RATE_TIME_NS  = 1000;
	localparam int US_CYCLES     = RATE_TIME_NS / CLK_PERIOD_NS;
	localparam logic [6:0] US_LAST = 7'(US_CYCLES - 1);
endpackage
`default_nettype wire

// *** rtl/cvr_ramp_if.sv ***
// link between the register bank and the setpoint ramp
`default_nettype none
interface cvr_ramp_if;
	logic        scalingEnable;
	logic [3:0]  slewRateCode;
	logic [7:0]  targetCode;
	logic [11:0] setpointMv;
	modport ctrl (output scalingEnable, output slewRateCode,
		output targetCode, input setpointMv);
	modport ramp (input scalingEnable, input slewRateCode,
		input targetCode, output setpointMv);
endinterface
`default_nettype wire

// *** rtl/cvr_ramp.sv ***
// step-down converter setpoint ramp at the selected slew rate
`default_nettype none
module cvr_ramp
	import cvr_pkg::*;
(
	input  wire logic clk,    // system clock
	input  wire logic resetn, // synchronous reset, active low
	input  wire logic ce,     // clock enable
	cvr_ramp_if.ramp  rif     // configuration in, setpoint out
);
	logic [11:0] spMv_r, spMv_nxt;
	logic [6:0]  usCnt_r, usCnt_nxt;
	logic [11:0] targetMv;
	logic [11:0] stepMv;
	logic [4:0]  codeClip;
	logic [3:0]  slewClip;

	// out-of-range codes saturate so the converter never overshoots
	always_comb begin
		codeClip = (rif.targetCode > STEP_DOWN_MAX) ? 5'(STEP_DOWN_MAX)
			: rif.targetCode[4:0];
		slewClip = (rif.slewRateCode > SLEW_CODE_MAX) ? SLEW_CODE_MAX
			: rif.slewRateCode;
		targetMv = 12'(STEP_DOWN_BASE_MV + 12'(codeClip) * CODE_STEP_MV);
		stepMv = 12'(slewClip) + 12'h001;
	end

	// one step of (code+1) mV per microsecond toward the target
	always_comb begin
		spMv_nxt = spMv_r;
		usCnt_nxt = usCnt_r;
		if (!rif.scalingEnable) begin
			spMv_nxt = targetMv;
			usCnt_nxt = 7'h00;
		end else if (usCnt_r == US_LAST) begin
			usCnt_nxt = 7'h00;
			if (spMv_r < targetMv) begin
				spMv_nxt = (12'(targetMv - spMv_r) > stepMv)
					? 12'(spMv_r + stepMv) : targetMv;
			end else if (spMv_r > targetMv) begin
				spMv_nxt = (12'(spMv_r - targetMv) > stepMv)
					? 12'(spMv_r - stepMv) : targetMv;
			end
		end else begin
			usCnt_nxt = 7'(usCnt_r + 7'h01);
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			spMv_r <= STEP_DOWN_RST_MV;
			usCnt_r <= 7'h00;
		end else if (ce) begin
			spMv_r <= spMv_nxt;
			usCnt_r <= usCnt_nxt;
		end
	end

	assign rif.setpointMv = spMv_r;
endmodule
`default_nettype wire

// *** rtl/cvr_regs.sv ***
// converter voltage and ramp configuration register bank
`default_nettype none
module cvr_regs
	import cvr_pkg::*;
#(
	parameter logic [7:0] FIRST_REG_RST = 8'h0C // variant reset code
) (
	input  wire logic        clk,            // system clock
	input  wire logic        resetn,         // synchronous reset, active low
	input  wire logic        ce,             // clock enable, freezes state
	input  wire logic [7:0]  regAddr,        // register pointer
	input  wire logic        regWrite,       // write strobe
	input  wire logic [7:0]  regWdata,       // write data
	input  wire logic        regRead,        // read strobe
	output logic      [7:0]  regRdata,       // read data
	output logic             regRvalid,      // read data valid pulse
	output logic             scalingEnable,  // dynamic scaling on
	output logic      [3:0]  slewRateCode,   // ramp rate code
	output logic      [7:0]  stepDownCode,   // step-down voltage code
	output logic      [7:0]  firstRegCode,   // first regulator code
	output logic      [7:0]  secondRegCode,  // second regulator code
	output logic      [11:0] stepDownSetMv   // ramped setpoint in mV
);
	logic       scalEn_r, scalEn_nxt;
	logic [3:0] slew_r, slew_nxt;
	logic [7:0] stepDown_r, stepDown_nxt;
	logic [7:0] firstReg_r, firstReg_nxt;
	logic [7:0] secondReg_r, secondReg_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	logic       rvalid_r, rvalid_nxt;
	logic [7:0] rampCtrlView;

	cvr_ramp_if rampLink ();

	// reserved bits are not stored at all, so they can only read zero
	assign rampCtrlView = {3'b000, scalEn_r, slew_r};

	// register writes, one byte per strobe
	always_comb begin
		scalEn_nxt = scalEn_r;
		slew_nxt = slew_r;
		stepDown_nxt = stepDown_r;
		firstReg_nxt = firstReg_r;
		secondReg_nxt = secondReg_r;
		if (regWrite) begin
			if (regAddr == RAMP_CTRL_ADDR) begin
				scalEn_nxt = regWdata[SCALING_ENABLE_BIT];
				slew_nxt = regWdata[SLEW_CODE_MSB:SLEW_CODE_LSB];
			end else if (regAddr == STEP_DOWN_ADDR) begin
				stepDown_nxt = regWdata;
			end else if (regAddr == FIRST_REG_ADDR) begin
				firstReg_nxt = regWdata;
			end else if (regAddr == SECOND_REG_ADDR) begin
				secondReg_nxt = regWdata;
			end
		end
	end

	// read path; unmapped pointers answer zero
	always_comb begin
		rvalid_nxt = regRead;
		rdata_nxt = rdata_r;
		if (regRead) begin
			if (regAddr == RAMP_CTRL_ADDR) begin
				rdata_nxt = rampCtrlView;
			end else if (regAddr == STEP_DOWN_ADDR) begin
				rdata_nxt = stepDown_r;
			end else if (regAddr == FIRST_REG_ADDR) begin
				rdata_nxt = firstReg_r;
			end else if (regAddr == SECOND_REG_ADDR) begin
				rdata_nxt = secondReg_r;
			end else begin
				rdata_nxt = READ_UNMAPPED;
			end
		end
	end

	// state registers; reset codes come from the package and parameter
	always_ff @(posedge clk) begin
		if (!resetn) begin
			scalEn_r <= SCALING_ENABLE_RST;
			slew_r <= SLEW_CODE_RST;
			stepDown_r <= STEP_DOWN_RST;
			firstReg_r <= FIRST_REG_RST;
			secondReg_r <= SECOND_REG_RST;
			rdata_r <= READ_UNMAPPED;
			rvalid_r <= 1'b0;
		end else if (ce) begin
			scalEn_r <= scalEn_nxt;
			slew_r <= slew_nxt;
			stepDown_r <= stepDown_nxt;
			firstReg_r <= firstReg_nxt;
			secondReg_r <= secondReg_nxt;
			rdata_r <= rdata_nxt;
			rvalid_r <= rvalid_nxt;
		end
	end

	// configuration to the ramp
	assign rampLink.scalingEnable = scalEn_r;
	assign rampLink.slewRateCode = slew_r;
	assign rampLink.targetCode = stepDown_r;

	cvr_ramp u_ramp (
		.clk    (clk),
		.resetn (resetn),
		.ce     (ce),
		.rif    (rampLink.ramp)
	);

	// every output is a flip-flop
	assign regRdata = rdata_r;
	assign regRvalid = rvalid_r;
	assign scalingEnable = scalEn_r;
	assign slewRateCode = slew_r;
	assign stepDownCode = stepDown_r;
	assign firstRegCode = firstReg_r;
	assign secondRegCode = secondReg_r;
	assign stepDownSetMv = rampLink.setpointMv;
endmodule
`default_nettype wire

// *** tb/cvr_regs_properties.sv ***
// port assertions for the ramp register bank
`default_nettype none
module cvr_regs_properties import cvr_pkg::*; (
	input wire logic        clk, // clock
	input wire logic        resetn, // reset
	input wire logic        ce, // enable
	input wire logic [7:0]  regAddr, // pointer
	input wire logic        regWrite, // write
	input wire logic [7:0]  regWdata, // wdata
	input wire logic        regRead, // read
	input wire logic [7:0]  regRdata, // rdata
	input wire logic        regRvalid, // valid
	input wire logic        scalingEnable, // dvs on
	input wire logic [3:0]  slewRateCode, // rate
	input wire logic [7:0]  stepDownCode, // code
	input wire logic [7:0]  firstRegCode, // code
	input wire logic [7:0]  secondRegCode, // code
	input wire logic [11:0] stepDownSetMv // setpoint
);
	// taken write address; 0x00 is not a register of this bank
	wire logic [7:0] wrAt = (ce && regWrite) ? regAddr : 8'h00;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	a_reserved_zero: assert property (ce && regRead &&
		regAddr == RAMP_CTRL_ADDR |=> !regRdata[7:5]) else $error("reserved set");
	a_scaling_bit: assert property (wrAt == RAMP_CTRL_ADDR |=>
		scalingEnable == $past(regWdata[4])) else $error("scaling bit");
	a_slew_code: assert property (wrAt == RAMP_CTRL_ADDR |=>
		slewRateCode == $past(regWdata[3:0])) else $error("slew code");
	a_step_code: assert property (wrAt == STEP_DOWN_ADDR |=>
		stepDownCode == $past(regWdata)) else $error("step-down code");
	a_first_code: assert property (wrAt == FIRST_REG_ADDR |=>
		firstRegCode == $past(regWdata)) else $error("first code");
	a_second_code: assert property (wrAt == SECOND_REG_ADDR |=>
		secondRegCode == $past(regWdata)) else $error("second code");
	// loose bound of 12 mV a cycle, still catches an instant jump
	a_slow_ramp: assert property ($past(scalingEnable) &&
		scalingEnable |-> 12'(stepDownSetMv - $past(stepDownSetMv)
		+ 12'h00C) <= 12'h018) else $error("setpoint jumped");
	// main scenarios reached
	c_reserved: cover property (regRvalid && regRdata == 8'h1F);
	c_ramp: cover property (scalingEnable && $changed(stepDownSetMv));
	c_first: cover property (wrAt == FIRST_REG_ADDR);
endmodule
bind cvr_regs cvr_regs_properties u_props (.*);
`default_nettype wire

// *** tb/tb_converter_voltage_ramp_regs.sv ***
// directed bench for the ramp register bank
`default_nettype none
module tb_converter_voltage_ramp_regs import cvr_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [7:0] FIRST_RST = 8'h0A; // variant under test
	logic        clk = 1'b0, resetn = 1'b0, ce = 1'b1;
	logic        regWrite = 1'b0, regRead = 1'b0, regRvalid, scalingEnable;
	logic [3:0]  slewRateCode;
	logic [7:0]  regAddr = 8'h00, regWdata = 8'h00, regRdata;
	logic [7:0]  stepDownCode, firstRegCode, secondRegCode;
	logic [11:0] stepDownSetMv;
	int          miscompares = 0, comparisons = 0, cycles = 0;
	cvr_regs #(.FIRST_REG_RST(FIRST_RST)) DUT (.*);
	// clock, and a ceiling well past the directed run
	always #5 clk = ~clk;
	always @(posedge clk) if (++cycles == 3000) begin
		miscompares++;
		stop_test();
	end
	task automatic stop_test();
		if (miscompares == 0 && comparisons > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(string what, logic [11:0] exp, logic [11:0] got);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// one access; strobe held to its taken edge, d is expected on a read
	task automatic bus(logic w, logic [7:0] a, logic [7:0] d);
		@(posedge clk);
		#1 regAddr = a;
		regWdata = d;
		regWrite = w;
		regRead = !w;
		@(posedge clk);
		#1 regWrite = 1'b0;
		regRead = 1'b0;
		if (!w) begin
			chk("rvalid", 12'h001, 12'(regRvalid));
			chk("rdata", 12'(d), 12'(regRdata));
		end
	endtask
	initial begin
		repeat (4) @(posedge clk);
		#1 resetn = 1'b1;
		bus(1'b0, RAMP_CTRL_ADDR, 8'h09);
		bus(1'b0, STEP_DOWN_ADDR, 8'h02);
		bus(1'b0, FIRST_REG_ADDR, FIRST_RST);
		bus(1'b0, SECOND_REG_ADDR, 8'h0E);
		// reserved bits dropped, out-of-range slew kept as written
		bus(1'b1, RAMP_CTRL_ADDR, 8'hFF);
		bus(1'b0, RAMP_CTRL_ADDR, 8'h1F);
		bus(1'b1, RAMP_CTRL_ADDR, 8'h0B);
		bus(1'b1, STEP_DOWN_ADDR, 8'h10);
		bus(1'b1, FIRST_REG_ADDR, 8'h11);
		bus(1'b1, SECOND_REG_ADDR, 8'h15);
		bus(1'b0, FIRST_REG_ADDR, 8'h11);
		bus(1'b0, SECOND_REG_ADDR, 8'h15);
		chk("slewRateCode", 12'h00B, 12'(slewRateCode));
		chk("scalingEnable", 12'h000, 12'(scalingEnable));
		chk("stepDownCode", 12'h010, 12'(stepDownCode));
		chk("firstRegCode", 12'h011, 12'(firstRegCode));
		chk("secondRegCode", 12'h015, 12'(secondRegCode));
		bus(1'b0, 8'h07, 8'h00);
		chk("setpoint", 12'h960, stepDownSetMv);
		// scaling on at 2 mV a step: 2400 creeps toward 800
		bus(1'b1, RAMP_CTRL_ADDR, 8'h11);
		bus(1'b1, STEP_DOWN_ADDR, 8'h00);
		repeat (250) @(posedge clk);
		#1 chk("ramp", 12'h001,
			12'(stepDownSetMv inside {[12'h95A:12'h95C]}));
		bus(1'b1, RAMP_CTRL_ADDR, 8'h01);
		@(posedge clk);
		#1 chk("setpoint", 12'h320, stepDownSetMv);
		// a write while the clock enable is low must not land
		ce = 1'b0;
		bus(1'b1, STEP_DOWN_ADDR, 8'h05);
		ce = 1'b1;
		bus(1'b0, STEP_DOWN_ADDR, 8'h00);
		stop_test();
	end
endmodule
`default_nettype wire
